// *** src/mstp_ctrl.v ***
// step translator, two pwm current loops and apb register file of the microstep controller
//
// Functional notes
// [R1] each bridge has its own comparator loop switching the bridge from current error
// [R2] pwm edges sit on the internal pwm counter with a fixed period
// [R3] high and low switch of a half-bridge never on together; dead time between
// [R4] two-bit output slope field lives in control register three
// [R5] switch off a switch whose overvoltage outlasts the transition time; code turns off all four gates of that bridge until period end
// [R6] enable bit low tri-states both bridges; pins and bus keep working
// [R7] writing enable one restarts regulation at present translator currents
// [R8] forward plus slow decay normally; fast decay when set point falls
// [R9] measured duty cycle per winding stored in its own status register
// [R10] set point not reached by 75 percent of period forces top regulation
// [R11] top/bottom flag per winding in that winding's status register
// [R12] steps become currents from resolution, polarity bits and the three pins
// [R13] resolution codes 000 1/16, 001 1/8, 010 1/4, 011 1/2
// [R14] reset gives 1/16 resolution and position 8
// [R15] at 1/16 each step moves position by exactly one
// [R16] coarser resolution clears unused low position bits
// [R17] misaligned position reaches valid row after one step up or two down; code reaches it in one step down too
// [R18] finer resolution keeps position, new low bits zero
// [R19] coil x follows cosine, coil y sine of position times 360/64
// [R20] direction is direction pin xor direction polarity
// [R21] step on step pin rising edge or command bit; bit self-clears
// [R22] run is run/hold pin xor polarity; hold freezes position
// [R23] code 101 one coil at a time, 111 both coils at 71 percent
// [R24] position wraps modulo 64
// [R25] step increment 1, 2, 4 or 8 by resolution, sign by direction
`timescale 1ns/1ps
`include "mstp_defs.vh"
module mstp_ctrl #(
    parameter PWM_CYCLES = `MSTP_PWM_CYCLES
)(
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire stepAdvancePin,
    input wire directionPin,
    input wire runHoldPin,
    input wire [1:0] currentAboveX,
    input wire [1:0] overVoltX,
    input wire [1:0] currentAboveY,
    input wire [1:0] overVoltY,
    output reg [3:0] gateX,
    output reg [3:0] gateY,
    output wire driveEnableX,
    output wire driveEnableY,
    output reg [7:0] setPointX,
    output reg [7:0] setPointY,
    output wire [1:0] slopeSelect
);
    // gate bits: {high0, low0, high1, low1}; comparator/overvoltage bits: [0]=coil sign, [1]=second
    reg driveOutputEnable;
    reg directionPolarity;
    reg runHoldPolarity;
    reg stepAdvanceCommand;
    reg [2:0] stepResolutionSelect;
    reg [1:0] slope;
    reg [5:0] translatorPosition;
    reg [2:0] syncStep, syncDir, syncRun;
    reg stepLevel, dirLevel, runLevel;
    reg [15:0] pwmCount;
    reg restart;
    reg [7:0] prevMagX, prevMagY;
    reg [15:0] dutyX, dutyY;
    reg topX, topY;
    wire wr = psel & penable & pwrite;
    localparam integer LATE_MARK = (PWM_CYCLES * 3) / 4;
    localparam integer DEAD_CYCLES = `MSTP_DEAD_CYCLES;
    wire [15:0] lateMark = LATE_MARK[15:0];
    wire periodEnd = (pwmCount == PWM_CYCLES - 1);

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign slopeSelect = slope; // [R4]
    assign driveEnableX = driveOutputEnable; // [R6]
    assign driveEnableY = driveOutputEnable; // [R6]

    // quarter-wave sine magnitude table, 255 = full scale
    function [7:0] sineQuarter;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: sineQuarter = 8'h00;
                4'h1: sineQuarter = 8'h19;
                4'h2: sineQuarter = 8'h32;
                4'h3: sineQuarter = 8'h4a;
                4'h4: sineQuarter = 8'h62;
                4'h5: sineQuarter = 8'h78;
                4'h6: sineQuarter = 8'h8e;
                4'h7: sineQuarter = 8'ha2;
                4'h8: sineQuarter = 8'hb4;
                4'h9: sineQuarter = 8'hc5;
                4'ha: sineQuarter = 8'hd4;
                4'hb: sineQuarter = 8'he1;
                4'hc: sineQuarter = 8'heb;
                4'hd: sineQuarter = 8'hf4;
                4'he: sineQuarter = 8'hfa;
                default: sineQuarter = 8'hfe;
            endcase
        end
    endfunction

    // sine of a 6-bit angle: {sign, magnitude}
    function [8:0] sineOf;
        input [5:0] a;
        reg [4:0] q;
        begin
            q = {1'b0, a[3:0]};
            if (a[4])
                q = 5'h10 - q;
            if (q == 5'h10)
                sineOf = {a[5], 8'hff};
            else
                sineOf = {a[5], sineQuarter(q[3:0])};
        end
    endfunction

    wire [8:0] sinY = sineOf(translatorPosition); // [R19]
    wire [8:0] cosX = sineOf(translatorPosition + 6'h10); // [R19]
    reg [8:0] targetX, targetY;
    always @*
    begin
        targetX = cosX;
        targetY = sinY;
        if (stepResolutionSelect == `MSTP_RES_FS1) // [R23]
        begin
            targetX = translatorPosition[4] ? 9'h000 : {translatorPosition[5], 8'hff};
            targetY = translatorPosition[4] ? {translatorPosition[5], 8'hff} : 9'h000;
        end
        else if (stepResolutionSelect == `MSTP_RES_FS2) // [R23]
        begin
            targetX = {cosX[8], 8'hb5};
            targetY = {sinY[8], 8'hb5};
        end
    end

    // step increment as a shift of the resolution
    reg [5:0] stepSize;
    reg [5:0] resMask;
    always @*
    begin
        case (stepResolutionSelect)
            `MSTP_RES_16: stepSize = 6'h01; // [R15] [R25]
            `MSTP_RES_8: stepSize = 6'h02; // [R25]
            `MSTP_RES_4: stepSize = 6'h04; // [R25]
            `MSTP_RES_2: stepSize = 6'h08; // [R25]
            default: stepSize = 6'h08;
        endcase
        resMask = ~(stepSize - 6'h01);
    end

    // three-stage synchronisers; a change counts when stages 2 and 3 agree
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            syncStep <= 3'h0;
            syncDir <= 3'h0;
            syncRun <= 3'h0;
            stepLevel <= 1'b0;
            dirLevel <= 1'b0;
            runLevel <= 1'b0;
        end
        else
        begin
            syncStep <= {syncStep[1:0], stepAdvancePin};
            syncDir <= {syncDir[1:0], directionPin};
            syncRun <= {syncRun[1:0], runHoldPin};
            if (syncStep[1] == syncStep[2])
                stepLevel <= syncStep[2];
            if (syncDir[1] == syncDir[2])
                dirLevel <= syncDir[2];
            if (syncRun[1] == syncRun[2])
                runLevel <= syncRun[2];
        end
    end

    wire stepPinEdge = (syncStep[1] == syncStep[2]) & syncStep[2] & ~stepLevel;
    wire direction = dirLevel ^ directionPolarity; // [R20]
    wire runMode = runLevel ^ runHoldPolarity; // [R22]
    wire stepTrigger = stepPinEdge | stepAdvanceCommand; // [R21]
    wire [2:0] newRes = pwdata[`MSTP_C2_RES_LSB +: 3];
    wire resWrite = wr & (paddr == `MSTP_ADDR_CTRL2);

    // translator
    reg [5:0] next_translatorPosition;
    always @*
    begin
        next_translatorPosition = translatorPosition;
        if (stepTrigger & runMode) // [R12] [R22]
        begin
            if (stepResolutionSelect == `MSTP_RES_FS1 || stepResolutionSelect == `MSTP_RES_FS2)
                next_translatorPosition = direction ? translatorPosition + 6'h10 : translatorPosition - 6'h10;
            else if ((translatorPosition & ~resMask) != 6'h00) // [R17]
                next_translatorPosition = direction ? (translatorPosition & resMask) + stepSize
                                                    : (translatorPosition & resMask);
            else
                next_translatorPosition = direction ? translatorPosition + stepSize // [R24] [R25]
                                                    : translatorPosition - stepSize;
        end
    end

    // coarser-mode mask for a resolution change
    reg [5:0] newMask;
    always @*
    begin
        case (newRes)
            `MSTP_RES_16: newMask = 6'h3f; // [R13]
            `MSTP_RES_8: newMask = 6'h3e; // [R13]
            `MSTP_RES_4: newMask = 6'h3c; // [R13]
            `MSTP_RES_2: newMask = 6'h38; // [R13]
            `MSTP_RES_FS1: newMask = 6'h30;
            `MSTP_RES_FS2: newMask = 6'h38;
            default: newMask = 6'h3f;
        endcase
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            translatorPosition <= `MSTP_RESET_POS; // [R14]
            stepResolutionSelect <= `MSTP_RESET_RES; // [R14]
            driveOutputEnable <= 1'b0;
            directionPolarity <= 1'b0;
            runHoldPolarity <= 1'b0;
            stepAdvanceCommand <= 1'b0;
            slope <= `MSTP_RESET_SLOPE;
            restart <= 1'b0;
        end
        else
        begin
            restart <= 1'b0;
            if (resWrite)
            begin
                stepResolutionSelect <= newRes;
                // coarser clears low bits; finer keeps the position as is
                translatorPosition <= translatorPosition & newMask; // [R16] [R18]
            end
            else
                translatorPosition <= next_translatorPosition;
            if (stepAdvanceCommand)
                stepAdvanceCommand <= 1'b0; // [R21]
            if (wr && paddr == `MSTP_ADDR_CTRL1)
            begin
                driveOutputEnable <= pwdata[`MSTP_C1_ENABLE];
                restart <= pwdata[`MSTP_C1_ENABLE]; // [R7]
                directionPolarity <= pwdata[`MSTP_C1_DIRPOL];
                runHoldPolarity <= pwdata[`MSTP_C1_RHPOL];
                stepAdvanceCommand <= pwdata[`MSTP_C1_STEPCMD]; // [R21]
            end
            if (wr && paddr == `MSTP_ADDR_CTRL3)
                slope <= pwdata[`MSTP_C3_SLOPE_LSB +: 2]; // [R4]
        end
    end

    // pwm loop per bridge: forward until current reached, then decay
    reg [15:0] onTime [0:1];
    reg reached [0:1];
    reg fastDecay [0:1];
    reg [7:0] deadCnt [0:1];
    reg [7:0] ovCnt [0:1];
    reg trip [0:1];
    reg [3:0] gateReq [0:1];
    reg [3:0] gateNow [0:1];
    wire [8:0] tgt [0:1];
    wire [1:0] above [0:1];
    wire [1:0] ov [0:1];
    assign tgt[0] = targetX;
    assign tgt[1] = targetY;
    assign above[0] = currentAboveX;
    assign above[1] = currentAboveY;
    assign ov[0] = overVoltX;
    assign ov[1] = overVoltY;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pwmCount <= 16'h0000;
        else if (periodEnd || restart) // [R2] [R7]
            pwmCount <= 16'h0000;
        else
            pwmCount <= pwmCount + 16'h0001;
    end

    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : bridge
            wire forward = ~reached[b] & ~trip[b];
            wire sgn = tgt[b][8];
            always @*
            begin
                // forward drives by sign; slow decay both low; fast decay reverses
                if (!forward)
                    gateReq[b] = fastDecay[b] ? (sgn ? 4'b1001 : 4'b0110) : 4'b0101; // [R8]
                else
                    gateReq[b] = sgn ? 4'b0110 : 4'b1001; // [R1]
                if (trip[b])
                    gateReq[b] = 4'b0000; // [R5]
            end
            always @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    reached[b] <= 1'b0;
                    fastDecay[b] <= 1'b0;
                    onTime[b] <= 16'h0000;
                    deadCnt[b] <= 8'h00;
                    gateNow[b] <= 4'h0;
                    ovCnt[b] <= 8'h00;
                    trip[b] <= 1'b0;
                end
                else
                begin
                    if (periodEnd || restart)
                    begin
                        reached[b] <= 1'b0; // [R2]
                        onTime[b] <= 16'h0000;
                        trip[b] <= 1'b0;
                    end
                    else
                    begin
                        if (above[b][0])
                            reached[b] <= 1'b1; // [R1]
                        if (forward)
                            onTime[b] <= onTime[b] + 16'h0001;
                    end
                    fastDecay[b] <= (b == 0 ? (targetX[7:0] < prevMagX) : (targetY[7:0] < prevMagY)); // [R8]
                    if (|ov[b] && gateNow[b] != 4'h0)
                    begin
                        if (ovCnt[b] >= `MSTP_TRANS_CYCLES)
                            trip[b] <= 1'b1; // [R5]
                        else
                            ovCnt[b] <= ovCnt[b] + 8'h01;
                    end
                    else
                        ovCnt[b] <= 8'h00;
                    // dead interval: all off before any new pattern
                    if (gateReq[b] != gateNow[b] && gateNow[b] != 4'h0)
                    begin
                        gateNow[b] <= 4'h0; // [R3]
                        deadCnt[b] <= DEAD_CYCLES[7:0];
                    end
                    else if (deadCnt[b] != 8'h00)
                        deadCnt[b] <= deadCnt[b] - 8'h01; // [R3]
                    else
                        gateNow[b] <= gateReq[b];
                end
            end
        end
    endgenerate

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gateX <= 4'h0;
            gateY <= 4'h0;
            setPointX <= 8'h00;
            setPointY <= 8'h00;
            prevMagX <= 8'h00;
            prevMagY <= 8'h00;
            dutyX <= 16'h0000;
            dutyY <= 16'h0000;
            topX <= 1'b0;
            topY <= 1'b0;
        end
        else
        begin
            gateX <= driveOutputEnable ? gateNow[0] : 4'h0; // [R6]
            gateY <= driveOutputEnable ? gateNow[1] : 4'h0; // [R6]
            setPointX <= targetX[7:0]; // [R19]
            setPointY <= targetY[7:0]; // [R19]
            if (periodEnd)
            begin
                prevMagX <= targetX[7:0];
                prevMagY <= targetY[7:0];
                dutyX <= onTime[0]; // [R9]
                dutyY <= onTime[1]; // [R9]
            end
            if (pwmCount == lateMark)
            begin
                topX <= ~reached[0]; // [R10] [R11]
                topY <= ~reached[1]; // [R10] [R11]
            end
        end
    end

    always @*
    begin
        case (paddr)
            `MSTP_ADDR_CTRL1: prdata = {28'h0, stepAdvanceCommand, runHoldPolarity, directionPolarity, driveOutputEnable};
            `MSTP_ADDR_CTRL2: prdata = {29'h0, stepResolutionSelect};
            `MSTP_ADDR_CTRL3: prdata = {30'h0, slope};
            `MSTP_ADDR_STATX: prdata = {15'h0, topX, dutyX}; // [R9] [R11]
            `MSTP_ADDR_STATY: prdata = {15'h0, topY, dutyY}; // [R9] [R11]
            `MSTP_ADDR_POS: prdata = {23'h0, runLevel, dirLevel, 1'b0, translatorPosition};
            default: prdata = 32'h0;
        endcase
    end
endmodule

// *** src/mstp_defs.vh ***
// register offsets, field positions, reset values and timing counts for the microstep controller
`ifndef MSTP_DEFS_VH
`define MSTP_DEFS_VH
`define MSTP_ADDR_CTRL1 12'h000
`define MSTP_ADDR_CTRL2 12'h004
`define MSTP_ADDR_CTRL3 12'h008
`define MSTP_ADDR_STATX 12'h00c
`define MSTP_ADDR_STATY 12'h010
`define MSTP_ADDR_POS 12'h014
`define MSTP_C1_ENABLE 0
`define MSTP_C1_DIRPOL 1
`define MSTP_C1_RHPOL 2
`define MSTP_C1_STEPCMD 3
`define MSTP_C2_RES_LSB 0
`define MSTP_C3_SLOPE_LSB 0
`define MSTP_RESET_RES 3'h0
`define MSTP_RESET_POS 6'h08
`define MSTP_RESET_SLOPE 2'h0
`define MSTP_RES_16 3'h0
`define MSTP_RES_8 3'h1
`define MSTP_RES_4 3'h2
`define MSTP_RES_2 3'h3
`define MSTP_RES_FS1 3'h5
`define MSTP_RES_FS2 3'h7
`define MSTP_CLK_NS 10
`define MSTP_PWM_PERIOD_NS 20000
`define MSTP_PWM_CYCLES (`MSTP_PWM_PERIOD_NS / `MSTP_CLK_NS)
`define MSTP_DEAD_NS 100
`define MSTP_DEAD_CYCLES ((`MSTP_DEAD_NS + `MSTP_CLK_NS - 1) / `MSTP_CLK_NS)
`define MSTP_TRANS_NS 500
`define MSTP_TRANS_CYCLES (`MSTP_TRANS_NS / `MSTP_CLK_NS)
`endif

// *** testbench/mstp_ctrl_asserts.sv ***
// concurrent checks on the microstep controller ports
`timescale 1ns/1ps
`include "mstp_defs.vh"
module mstp_ctrl_asserts #(
    parameter PWM_CYCLES = 64
)(
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] gateX,
    input wire [3:0] gateY,
    input wire driveEnableX,
    input wire driveEnableY,
    input wire [1:0] slopeSelect
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire wrAcc = psel && penable && pwrite && pready;
    wire wrCtrl1 = wrAcc && (paddr == `MSTP_ADDR_CTRL1);
    wire wrCtrl3 = wrAcc && (paddr == `MSTP_ADDR_CTRL3);
    wire enBit = pwdata[`MSTP_C1_ENABLE];
    wire [1:0] slopeBits = pwdata[1:0];
    a_no_shoot_through:
        assert property (!(gateX[3] && gateX[2]) && !(gateX[1] && gateX[0]) && !(gateY[3] && gateY[2])
            && !(gateY[1] && gateY[0])) else $error("half-bridge switches on together");
    a_dead_time_x:
        assert property ($fell(gateX[3]) |-> !gateX[2] [*8]) else $error("x low switch on without dead time");
    a_dead_time_y:
        assert property ($fell(gateY[2]) |-> !gateY[3] [*8]) else $error("y high switch on without dead time");
    a_off_disabled_x:
        assert property (!driveEnableX && $past(!driveEnableX) |-> gateX == 4'h0) else $error("x gates on while off");
    a_off_disabled_y:
        assert property ((!driveEnableY) [*2] |-> gateY == 4'h0) else $error("y gates on while off");
    a_enable_write:
        assert property (wrCtrl1 |=> driveEnableX == $past(enBit) && driveEnableY == $past(enBit))
            else $error("enable does not follow write");
    a_enable_hold:
        assert property (!wrCtrl1 |=> $stable(driveEnableX)) else $error("enable changed without write");
    a_slope_write:
        assert property (wrCtrl3 |=> slopeSelect == $past(slopeBits)) else $error("slope does not follow write");
    a_slope_hold:
        assert property (!wrCtrl3 |=> $stable(slopeSelect)) else $error("slope changed without write");
endmodule
bind mstp_ctrl mstp_ctrl_asserts #(.PWM_CYCLES(PWM_CYCLES)) u_asserts (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .gateX(gateX),
    .gateY(gateY), .driveEnableX(driveEnableX), .driveEnableY(driveEnableY), .slopeSelect(slopeSelect));

// *** testbench/mstp_step_source.sv ***
// step, direction and run/hold pin source of the controlling microcontroller
`timescale 1ns/1ps
module mstp_step_source(
    output logic stepAdvancePin,
    output logic directionPin,
    output logic runHoldPin
);
    logic linkClk;
    initial
    begin
        linkClk = 1'b0;
        stepAdvancePin = 1'b0;
        directionPin = 1'b0;
        runHoldPin = 1'b0;
        #23;
        forever #80 linkClk = ~linkClk;
    end
    // levels settle one link period before any step edge
    task automatic set_levels(input logic d, input logic r);
        @(posedge linkClk);
        directionPin <= d;
        runHoldPin <= r;
        @(posedge linkClk);
    endtask
    task automatic pulse(input logic d, input logic r);
        set_levels(d, r);
        stepAdvancePin <= 1'b1;
        @(posedge linkClk);
        stepAdvancePin <= 1'b0;
        @(posedge linkClk);
    endtask
endmodule

// *** testbench/test_mstp_ctrl.sv ***
// self-checking bench for the microstep controller
`timescale 1ns/1ps
`include "mstp_defs.vh"
module test_mstp_ctrl;
    localparam int PWM = 64;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, stepPin, dirPin, runPin, enX, enY;
    logic [1:0] aboveX = 2'b00;
    logic [1:0] aboveY = 2'b00;
    logic [3:0] gateX, gateY;
    logic [7:0] spX, spY;
    logic [1:0] slope;
    logic [5:0] pos = 6'h08;
    logic [2:0] res = 3'h0;
    logic dp = 1'b0;
    logic rp = 1'b1;
    logic en = 1'b1;
    int mismatches = 0;
    int numChecks = 0;
    int cycles = 0;
    mstp_ctrl #(.PWM_CYCLES(PWM)) dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stepAdvancePin(stepPin), .directionPin(dirPin), .runHoldPin(runPin), .currentAboveX(aboveX),
        .overVoltX(2'b00), .currentAboveY(aboveY), .overVoltY(2'b00), .gateX(gateX), .gateY(gateY),
        .driveEnableX(enX), .driveEnableY(enY), .setPointX(spX), .setPointY(spY), .slopeSelect(slope));
    mstp_step_source src (.stepAdvancePin(stepPin), .directionPin(dirPin), .runHoldPin(runPin));
    always #5 clk = ~clk;
    task automatic print_verdict();
        if (mismatches == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_true(input logic ok);
        numChecks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t condition not met", $time);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctrl1(input logic cmd);
        apb(`MSTP_ADDR_CTRL1, 1'b1, {28'h0, cmd, rp, dp, en});
    endtask
    task automatic set_res(input logic [2:0] r);
        res = r;
        // a resolution write clears the position bits that the new mode leaves unused
        pos = r[2] ? (pos & (r[1] ? 6'h38 : 6'h30)) : (pos & ~((6'd1 << r[1:0]) - 6'd1));
        apb(`MSTP_ADDR_CTRL2, 1'b1, {29'h0, r});
    endtask
    // misaligned position goes to next aligned step up, aligned floor down
    function automatic logic [5:0] next_pos(input logic [5:0] p, input logic [2:0] r, input logic up);
        logic [5:0] inc;
        logic [5:0] fl;
        inc = r[2] ? 6'd16 : 6'd1 << r[1:0];
        fl = r[2] ? p : p & ~(inc - 6'd1);
        if (fl != p)
            return up ? fl + inc : fl;
        return up ? p + inc : p - inc;
    endfunction
    task automatic step(input logic d, input logic r, input logic cmd);
        if (cmd)
        begin
            src.set_levels(d, r);
            ctrl1(1'b1);
            repeat (4) @(posedge clk);
            apb(`MSTP_ADDR_CTRL1, 1'b0, 32'h0);
            chk(32'(q[3]), 32'h0);
        end
        else
            src.pulse(d, r);
        repeat (8) @(posedge clk);
        if (r ^ rp)
            pos = next_pos(pos, res, d ^ dp);
        apb(`MSTP_ADDR_POS, 1'b0, 32'h0);
        chk(32'(q[5:0]), 32'(pos));
        chk(32'(q[8:7]), 32'({r, d}));
    endtask
    task automatic set_points(input logic [7:0] x, input logic [7:0] y);
        repeat (PWM + 10) @(posedge clk);
        chk(32'(spX), 32'(x));
        chk(32'(spY), 32'(y));
    endtask
    initial
    begin
        int i;
        int j;
        logic d, rr, c;
        void'($urandom(32'h20f54824));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        apb(`MSTP_ADDR_POS, 1'b0, 32'h0);
        chk(32'(q[5:0]), 32'h8);
        apb(`MSTP_ADDR_CTRL2, 1'b0, 32'h0);
        chk(32'(q[2:0]), 32'(`MSTP_RES_16));
        apb(12'h040, 1'b0, 32'h0);
        chk(q, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            apb(`MSTP_ADDR_CTRL3, 1'b1, 32'(i));
            @(posedge clk);
            chk(32'(slope), 32'(i));
        end
        ctrl1(1'b0);
        repeat (PWM + 10) @(posedge clk);
        chk(32'(spX), 32'(spY));
        chk_true(spX != 8'h00);
        for (i = 0; i < 2; i++)
        begin
            aboveX <= i ? 2'b11 : 2'b00;
            aboveY <= i ? 2'b11 : 2'b00;
            repeat (3 * PWM) @(posedge clk);
            for (j = 0; j < 2; j++)
            begin
                apb(j ? `MSTP_ADDR_STATY : `MSTP_ADDR_STATX, 1'b0, 32'h0);
                chk(32'(q[16]), 32'(i == 0));
                chk_true((q[15:0] > PWM / 2) == (i == 0));
            end
        end
        set_res(`MSTP_RES_2);
        step(1'b0, 1'b0, 1'b0);
        set_points(8'hff, 8'h00);
        step(1'b0, 1'b0, 1'b0);
        set_res(`MSTP_RES_FS2);
        step(1'b1, 1'b0, 1'b0);
        chk(32'(spX), 32'(spY));
        set_res(`MSTP_RES_16);
        repeat (8) step(1'b0, 1'b0, 1'b0);
        set_res(`MSTP_RES_FS1);
        step(1'b1, 1'b0, 1'b0);
        set_points(8'h00, 8'hff);
        set_res(`MSTP_RES_16);
        step(1'b1, 1'b0, 1'b0);
        set_res(`MSTP_RES_4);
        step(1'b0, 1'b0, 1'b0);
        en = 1'b0;
        ctrl1(1'b0);
        repeat (5) @(posedge clk);
        chk(32'({enX, enY, gateX, gateY}), 32'h0);
        step(1'b1, 1'b0, 1'b0);
        for (i = 0; i < 30; i++)
        begin
            set_res(3'($urandom % 4));
            rp = 1'($urandom);
            dp = 1'($urandom);
            en = ($urandom % 4) != 0;
            aboveX <= 2'($urandom);
            aboveY <= 2'($urandom);
            ctrl1(1'b0);
            d = 1'($urandom);
            rr = 1'($urandom);
            c = 1'($urandom);
            step(d, rr, c && (rr ^ rp));
        end
        print_verdict();
    end
endmodule
